// ### logic/tsm_monitor.sv
// Trail supervision: code check, remote indications, AIS, SF/SD.
// Behaviour
// - Recompute code, count each mismatching bit.
// - Return near-end defect as remote defect.
// - Return exact mismatch count as remote error.
// - Discard far-end errors in seconds with RDI.
// - Unidirectional trail: ignore remote indications.
// - Defect replaces traffic with all-ONEs.
// - Insert all-ONEs on local defects only.
// - Detect incoming AIS via K2 bits 6-8.
// - Detect pointer AIS via H1 and H2.
// - Sink feeding source: flag alarm pattern type.
// - Source given AIS plus server fail outputs ONEs.
// - Pointer AIS declares defect and inserts ONEs.
// - Signal fail and degrade from defects.
// - Enhanced: unequipped counts only with zero trace.
// - Unknown trace: disable mismatch, keep trace readable.
// - Near-end defect voids far-end information.
`timescale 1ns/1ps
`default_nettype none
module tsm_monitor #(
    parameter int unsigned SEC_CYC = tsm_pkg::SEC_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_valid,
    input  wire logic        rx_sof,
    input  wire logic [7:0]  rx_data,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    output logic [1:0]       tx_alarm_type,
    input  wire logic        src_valid,
    input  wire logic [7:0]  src_data,
    output logic             src_out_valid,
    output logic [7:0]       src_out_data,
    input  wire logic        server_fail_flag,
    input  wire logic        frame_loss_defect,
    input  wire logic        unequipped_defect,
    input  wire logic        trace_mismatch_defect,
    input  wire logic        degraded_defect,
    input  wire logic        accepted_trace_zero,
    output logic             rdi_out,
    output logic [3:0]       rei_out,
    output logic             sig_fail,
    output logic             sig_degrade,
    output logic             irq
);
    generate
        if (SEC_CYC < 2) begin : g_bad
            $error("SEC_CYC must be at least 2");
        end
    endgenerate

    function automatic logic [3:0] ones(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction : ones

    function automatic logic at(input logic [7:0] p, input int unsigned k);
        return p == k[7:0];
    endfunction : at

    logic [7:0]  pos;
    logic [7:0]  bip_acc;
    logic [7:0]  bip_prev;
    logic        bip_ok;
    logic [5:0]  ctrl;
    logic [4:0]  int_mask;
    logic [4:0]  int_stat;
    logic [31:0] ne_err;
    logic [31:0] fe_err;
    logic [31:0] fe_pend;
    logic        fe_void;
    logic [31:0] sec_cnt;
    logic [7:0]  rx_trace;
    logic        alarm_pattern_defect;
    logic        admin_unit_alarm_defect;
    logic        fe_defect;
    logic [7:0]  h1_byte;
    logic        near_def;
    logic        next_sf;
    logic        code_err;
    logic [3:0]  code_cnt;
    logic        fe_take;
    logic        sec_end;
    logic        rd_stat;
    logic        acc;
    logic [4:0]  ev;
    logic        prev_ais;

    // Byte position within the frame; a start marker realigns it.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pos <= 8'h00;
        end else if (rx_valid) begin
            if (rx_sof) begin
                pos <= 8'h01;
            end else if (at(pos, tsm_pkg::FRAME_LEN - 1)) begin
                pos <= 8'h00;
            end else begin
                pos <= pos + 8'h01;
            end
        end
    end

    // Parity of each frame is checked against the code in the next one.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bip_acc  <= 8'h00;
            bip_prev <= 8'h00;
            bip_ok   <= 1'b0;
        end else if (rx_valid) begin
            if (rx_sof) begin
                bip_prev <= bip_acc;
                bip_ok   <= 1'b1;
                bip_acc  <= rx_data;
            end else begin
                bip_acc  <= bip_acc ^ rx_data;
            end
        end
    end

    // Code byte comparison; each differing bit is one error.
    assign code_cnt = ones(rx_data ^ bip_prev);
    assign code_err = rx_valid && !rx_sof && bip_ok
                      && at(pos, tsm_pkg::CODE_POS) && code_cnt != 4'h0;

    // Incoming AIS from the overhead, held until the byte is seen again.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alarm_pattern_defect    <= 1'b0;
            admin_unit_alarm_defect <= 1'b0;
            h1_byte                 <= 8'h00;
            rx_trace                <= 8'h00;
        end else if (rx_valid && !rx_sof) begin
            if (at(pos, tsm_pkg::K2_POS)) begin
                alarm_pattern_defect <= rx_data[2:0] == 3'h7;
            end
            if (at(pos, tsm_pkg::H1_POS)) begin
                h1_byte <= rx_data;
            end
            if (at(pos, tsm_pkg::H2_POS)) begin
                admin_unit_alarm_defect <= h1_byte == 8'hff
                                           && rx_data == 8'hff;
            end
            if (at(pos, tsm_pkg::TRACE_POS)) begin
                rx_trace <= rx_data;
            end
        end
    end

    // Only locally seen defects, incoming AIS included, force ONEs.
    assign near_def = frame_loss_defect | server_fail_flag
                      | alarm_pattern_defect | admin_unit_alarm_defect;

    // Traffic path; ONEs begin the cycle after the defect is present.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_valid      <= 1'b0;
            tx_data       <= 8'h00;
            tx_alarm_type <= tsm_pkg::TYPE_NONE;
        end else begin
            tx_valid <= rx_valid;
            tx_data  <= near_def ? 8'hff : rx_data;
            tx_alarm_type <= (near_def && ctrl[tsm_pkg::C_FEED_SRC])
                ? ctrl[tsm_pkg::C_TYPE_LSB +: 2] : tsm_pkg::TYPE_NONE;
        end
    end

    // Source path: AIS with server fail stays all ONEs.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_out_valid <= 1'b0;
            src_out_data  <= 8'h00;
        end else begin
            src_out_valid <= src_valid;
            src_out_data  <= server_fail_flag ? 8'hff : src_data;
        end
    end

    // Return direction indications.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdi_out <= 1'b0;
            rei_out <= 4'h0;
        end else begin
            rdi_out <= near_def;
            if (rx_valid && !rx_sof && at(pos, tsm_pkg::CODE_POS)) begin
                rei_out <= bip_ok ? code_cnt : 4'h0;
            end
        end
    end

    // Protection conditions; trace mismatch only when expected is known.
    always_comb begin
        next_sf = server_fail_flag | alarm_pattern_defect;
        if (unequipped_defect && (!ctrl[tsm_pkg::C_ENHANCED]
                                  || accepted_trace_zero)) begin
            next_sf = 1'b1;
        end
        if (trace_mismatch_defect && ctrl[tsm_pkg::C_TRC_KNOWN]) begin
            next_sf = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sig_fail    <= 1'b0;
            sig_degrade <= 1'b0;
        end else begin
            sig_fail    <= next_sf;
            sig_degrade <= degraded_defect;
        end
    end

    // Far-end byte is used only on a bidirectional trail.
    assign fe_take = rx_valid && !rx_sof && at(pos, tsm_pkg::FE_POS)
                     && ctrl[tsm_pkg::C_BIDIR];
    assign sec_end = sec_cnt == SEC_CYC - 1;

    // A second with remote or near-end defect loses its far-end errors.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt   <= 32'h0;
            fe_pend   <= 32'h0;
            fe_void   <= 1'b0;
            fe_err    <= 32'h0;
            fe_defect <= 1'b0;
        end else begin
            sec_cnt <= sec_end ? 32'h0 : sec_cnt + 32'h1;
            if (fe_take) begin
                fe_defect <= rx_data[tsm_pkg::RDI_BIT] && !near_def;
            end else if (!ctrl[tsm_pkg::C_BIDIR]) begin
                fe_defect <= 1'b0;
            end
            if (sec_end) begin
                if (!fe_void) begin
                    fe_err <= fe_err + fe_pend;
                end
                fe_pend <= 32'h0;
                fe_void <= near_def;
            end
            // A byte on the boundary belongs to the second that starts.
            if (fe_take) begin
                fe_pend <= (sec_end ? 32'h0 : fe_pend)
                    + {28'h0, rx_data[tsm_pkg::REI_LSB +: 4]};
            end
            if ((fe_take && rx_data[tsm_pkg::RDI_BIT]) || near_def) begin
                fe_void <= 1'b1;
            end
        end
    end

    // Near-end error total.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ne_err <= 32'h0;
        end else if (code_err) begin
            ne_err <= ne_err + {28'h0, code_cnt};
        end
    end

    assign acc     = psel && penable;
    assign rd_stat = acc && !pwrite && paddr == tsm_pkg::A_INT_STAT;

    // Control and mask registers.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl     <= tsm_pkg::CTRL_RST;
            int_mask <= tsm_pkg::MASK_RST;
        end else if (acc && pwrite) begin
            if (paddr == tsm_pkg::A_CTRL) begin
                ctrl <= pwdata[5:0];
            end
            if (paddr == tsm_pkg::A_INT_MASK) begin
                int_mask <= pwdata[4:0];
            end
        end
    end

    // Rising edges of the watched conditions, and every code error, become events.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_ais <= 1'b0;
        end else begin
            prev_ais <= near_def;
        end
    end

    assign ev[tsm_pkg::I_SF]     = next_sf && !sig_fail;
    assign ev[tsm_pkg::I_SD]     = degraded_defect && !sig_degrade;
    assign ev[tsm_pkg::I_AIS]    = near_def && !prev_ais;
    assign ev[tsm_pkg::I_CODE]   = code_err;
    assign ev[tsm_pkg::I_FE_DEF] = fe_take && rx_data[tsm_pkg::RDI_BIT]
                                   && !fe_defect && !near_def;

    // Sticky status cleared by reading it; a new event wins the clear.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            int_stat <= 5'h00;
        end else begin
            int_stat <= (rd_stat ? 5'h00 : int_stat) | ev;
        end
    end

    assign irq = |(int_stat & int_mask);

    // Zero-wait slave; unmapped addresses answer with an error.
    assign pready = 1'b1;
    always_comb begin
        prdata  = 32'h0;
        pslverr = 1'b0;
        unique case (paddr)
            tsm_pkg::A_CTRL:     prdata = {26'h0, ctrl};
            tsm_pkg::A_STATUS:   prdata = {26'h0, fe_defect, sig_degrade,
                                 sig_fail, admin_unit_alarm_defect,
                                 alarm_pattern_defect, near_def};
            tsm_pkg::A_INT_STAT: prdata = {27'h0, int_stat};
            tsm_pkg::A_INT_MASK: prdata = {27'h0, int_mask};
            tsm_pkg::A_NE_ERR:   prdata = ne_err;
            tsm_pkg::A_FE_ERR:   prdata = fe_err;
            tsm_pkg::A_TRACE:    prdata = {24'h0, rx_trace};
            default:             pslverr = psel && penable;
        endcase
    end

    sequence s_defect_byte;
        rx_valid && near_def;
    endsequence

    sequence s_code_byte;
        rx_valid && !rx_sof && bip_ok && at(pos, tsm_pkg::CODE_POS);
    endsequence

    a_ais_fill: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_defect_byte |=> tx_valid && tx_data == 8'hff)
        else $error("traffic not replaced by all ones");

    a_ais_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rx_valid && !near_def |=> tx_data == $past(rx_data))
        else $error("clean traffic altered");

    a_rei_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_code_byte |=> rei_out == ones($past(rx_data ^ bip_prev)))
        else $error("remote error count wrong");

    a_rdi_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        near_def [*2] |=> rdi_out [*1])
        else $error("remote defect not returned");

    a_sf_tim: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctrl[tsm_pkg::C_TRC_KNOWN] && !server_fail_flag
        && !alarm_pattern_defect && !unequipped_defect |=> !sig_fail)
        else $error("fail raised from disabled trace check");

    a_sf_uneq: assert property (@(posedge clk_sys) disable iff (!rst_n)
        unequipped_defect && !ctrl[tsm_pkg::C_ENHANCED] |=> sig_fail)
        else $error("unequipped did not raise fail");

    a_sd_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sig_degrade == $past(degraded_defect))
        else $error("degrade not following defect");

    a_src_ais: assert property (@(posedge clk_sys) disable iff (!rst_n)
        src_valid && server_fail_flag |=> src_out_data == 8'hff)
        else $error("source did not send all ones");

    a_fe_void: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sec_end && fe_void |=> $stable(fe_err))
        else $error("far-end errors kept in void second");

    a_fe_unidir: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctrl[tsm_pkg::C_BIDIR] && !sec_end |=> fe_pend == $past(fe_pend))
        else $error("remote errors used on one-way trail");

    a_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq == |(int_stat & int_mask))
        else $error("interrupt line wrong");
endmodule : tsm_monitor
`default_nettype wire

// ### logic/tsm_pkg.sv
// Constants shared by the trail supervision monitor.
`default_nettype none
package tsm_pkg;
    // Frame layout: byte positions within one frame.
    localparam int unsigned FRAME_LEN  = 16;
    localparam int unsigned CODE_POS   = 2;
    localparam int unsigned FE_POS     = 3;
    localparam int unsigned K2_POS     = 4;
    localparam int unsigned H1_POS     = 5;
    localparam int unsigned H2_POS     = 6;
    localparam int unsigned TRACE_POS  = 7;
    // Return byte fields: remote error count and remote defect bit.
    localparam int unsigned REI_LSB    = 4;
    localparam int unsigned RDI_BIT    = 3;
    // Register byte addresses.
    localparam logic [7:0] A_CTRL      = 8'h00;
    localparam logic [7:0] A_STATUS    = 8'h04;
    localparam logic [7:0] A_INT_STAT  = 8'h08;
    localparam logic [7:0] A_INT_MASK  = 8'h0c;
    localparam logic [7:0] A_NE_ERR    = 8'h10;
    localparam logic [7:0] A_FE_ERR    = 8'h14;
    localparam logic [7:0] A_TRACE     = 8'h18;
    // Control fields and reset values.
    localparam int unsigned C_BIDIR    = 0;
    localparam int unsigned C_TRC_KNOWN = 1;
    localparam int unsigned C_ENHANCED = 2;
    localparam int unsigned C_FEED_SRC = 3;
    localparam int unsigned C_TYPE_LSB = 4;
    localparam logic [5:0] CTRL_RST    = 6'h01;
    localparam logic [4:0] MASK_RST    = 5'h00;
    // Interrupt event bit positions.
    localparam int unsigned I_SF       = 0;
    localparam int unsigned I_SD       = 1;
    localparam int unsigned I_AIS      = 2;
    localparam int unsigned I_CODE     = 3;
    localparam int unsigned I_FE_DEF   = 4;
    localparam int unsigned N_INT      = 5;
    // Alarm pattern types handed to a directly fed source.
    localparam logic [1:0] TYPE_NONE   = 2'h0;
    // Performance second.
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned SEC_TIME_NS   = 1000000000;
    localparam int unsigned SEC_CYCLES    = SEC_TIME_NS / CLK_PERIOD_NS;
endpackage : tsm_pkg
`default_nettype wire

// ### tb/tsm_far_end.sv
// Far-end trail source model that sends frames to the monitor.
`timescale 1ns/1ps
`default_nettype none
module tsm_far_end (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       k2_ais,
    input  wire logic       ptr_ais,
    input  wire logic       rdi_val,
    input  wire logic [3:0] rei_val,
    input  wire logic       corrupt_tog,
    input  wire logic [7:0] trace_val,
    output logic            rx_valid,
    output logic            rx_sof,
    output logic [7:0]      rx_data
);
    logic [4:0] pos;
    logic [7:0] run_par;
    logic [7:0] prev_par;
    logic       seen_tog;
    logic       bad;
    logic [7:0] byte_val;

    // Byte to launch next; a toggle of corrupt_tog spoils one code byte.
    always_comb begin
        case (pos)
            5'd0: byte_val = 8'ha5;
            5'd1: byte_val = 8'h5a;
            5'd2: byte_val = prev_par ^ (bad ? 8'h03 : 8'h00);
            5'd3: byte_val = {rei_val, rdi_val, 3'b000};
            5'd4: byte_val = {5'h00, {3{k2_ais}}};
            5'd5, 5'd6: byte_val = ptr_ais ? 8'hff : {3'h3, pos};
            5'd7: byte_val = trace_val;
            default: byte_val = {3'h4, pos};
        endcase
    end

    // One byte a cycle, then an idle gap that shows the inverse of the last
    // byte, so a design that samples outside valid sees junk, not old data.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pos <= 5'd0;
            run_par <= 8'h00;
            prev_par <= 8'h00;
            seen_tog <= 1'b0;
            bad <= 1'b0;
            rx_valid <= 1'b0;
            rx_sof <= 1'b0;
            rx_data <= 8'h00;
        end else if (pos == 5'd16) begin
            rx_valid <= 1'b0;
            rx_sof <= 1'b0;
            rx_data <= ~rx_data;
            pos <= 5'd0;
        end else begin
            rx_valid <= 1'b1;
            rx_sof <= (pos == 5'd0);
            rx_data <= byte_val;
            pos <= pos + 5'd1;
            run_par <= (pos == 5'd0) ? byte_val : (run_par ^ byte_val);
            if (pos == 5'd0) begin
                prev_par <= run_par;
                bad <= (corrupt_tog != seen_tog);
                seen_tog <= corrupt_tog;
            end
        end
    end
endmodule : tsm_far_end
`default_nettype wire

// ### tb/tsm_monitor_test.sv
// Self-checking testbench for the trail supervision monitor.
`timescale 1ns/1ps
`default_nettype none
module tsm_monitor_test;
    logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, rx_data, tx_data, src_data, src_out_data, trace_val;
    logic [31:0] pwdata, prdata;
    logic        rx_valid, rx_sof, tx_valid, src_valid, src_out_valid;
    logic        server_fail_flag, frame_loss_defect, unequipped_defect;
    logic        trace_mismatch_defect, degraded_defect, accepted_trace_zero;
    logic        rdi_out, sig_fail, sig_degrade, irq;
    logic        k2_ais, ptr_ais, rdi_val, corrupt_tog;
    logic [1:0]  tx_alarm_type;
    logic [3:0]  rei_out, rei_val;
    int          err_count, checks_done;

    // Short performance second keeps the far-end tests brief.
    tsm_monitor #(.SEC_CYC(100)) tsm_monitor_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_alarm_type(tx_alarm_type), .src_valid(src_valid),
        .src_data(src_data), .src_out_valid(src_out_valid),
        .src_out_data(src_out_data), .server_fail_flag(server_fail_flag),
        .frame_loss_defect(frame_loss_defect),
        .unequipped_defect(unequipped_defect),
        .trace_mismatch_defect(trace_mismatch_defect),
        .degraded_defect(degraded_defect),
        .accepted_trace_zero(accepted_trace_zero), .rdi_out(rdi_out),
        .rei_out(rei_out), .sig_fail(sig_fail), .sig_degrade(sig_degrade),
        .irq(irq));

    // Far end of the trail.
    tsm_far_end tsm_far_end_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .k2_ais(k2_ais),
        .ptr_ais(ptr_ais), .rdi_val(rdi_val), .rei_val(rei_val),
        .corrupt_tog(corrupt_tog), .trace_val(trace_val),
        .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_data(rx_data));

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chb

    // One APB transfer; request held until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask : rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask : rd_chk

    // Waiting relies on the watchdog to cut a missing frame start short.
    task automatic wait_frames(input int n);
        repeat (n) do @(posedge clk_sys); while (!(rx_valid && rx_sof));
    endtask : wait_frames

    // Byte 0 of the next frame reaches tx one cycle after it is received.
    task automatic tx_chk(input logic ones);
        wait_frames(1);
        @(posedge clk_sys);
        chk({24'h0, tx_data}, ones ? 32'hff : 32'ha5);
    endtask : tx_chk

    task automatic t_regs;
        logic [31:0] d;
        logic        e;
        rd_chk(tsm_pkg::A_CTRL, {26'h0, tsm_pkg::CTRL_RST});
        rd_chk(tsm_pkg::A_INT_MASK, {27'h0, tsm_pkg::MASK_RST});
        rd_chk(tsm_pkg::A_FE_ERR, 32'h0);
        wr(tsm_pkg::A_STATUS, 32'hff);
        rd_chk(tsm_pkg::A_STATUS, 32'h0);
        apb(1'b0, 8'h1c, 32'h0, d, e);
        chb(e, 1'b1);
        chk(d, 32'h0);
        rd_chk(tsm_pkg::A_TRACE, 32'h47);
    endtask : t_regs

    task automatic t_code;
        logic [31:0] d;
        rd(tsm_pkg::A_INT_STAT, d);
        wr(tsm_pkg::A_INT_MASK, 32'h1 << tsm_pkg::I_CODE);
        rd_chk(tsm_pkg::A_NE_ERR, 32'h0);
        corrupt_tog <= ~corrupt_tog;
        wait_frames(1);
        repeat (3) @(posedge clk_sys);
        chk({28'h0, rei_out}, 32'h2);
        rd_chk(tsm_pkg::A_NE_ERR, 32'h2);
        chb(irq, 1'b1);
        rd_chk(tsm_pkg::A_INT_STAT, 32'h1 << tsm_pkg::I_CODE);
        @(posedge clk_sys);
        chb(irq, 1'b0);
        wait_frames(2);
        chk({28'h0, rei_out}, 32'h0);
    endtask : t_code

    // Incoming alarm in K2 or in the pointer bytes; both lift afterwards.
    task automatic t_ais(input logic ptr);
        logic [31:0] d;
        if (ptr) ptr_ais <= 1'b1;
        else k2_ais <= 1'b1;
        wait_frames(2);
        tx_chk(1'b1);
        rd(tsm_pkg::A_STATUS, d);
        chb(d[ptr ? 2 : 1], 1'b1);
        chb(sig_fail, !ptr);
        chb(rdi_out, 1'b1);
        k2_ais <= 1'b0;
        ptr_ais <= 1'b0;
        wait_frames(2);
        tx_chk(1'b0);
        chb(rdi_out, 1'b0);
    endtask : t_ais

    task automatic sf_case(input logic [31:0] ctrl, input logic [4:0] in,
                           input logic sf, input logic sd);
        wr(tsm_pkg::A_CTRL, ctrl);
        {server_fail_flag, unequipped_defect, trace_mismatch_defect,
         accepted_trace_zero, degraded_defect} <= in;
        repeat (3) @(posedge clk_sys);
        chb(sig_fail, sf);
        chb(sig_degrade, sd);
    endtask : sf_case

    task automatic t_sf;
        sf_case(32'h01, 5'b10000, 1'b1, 1'b0);
        sf_case(32'h01, 5'b01000, 1'b1, 1'b0);
        sf_case(32'h05, 5'b01000, 1'b0, 1'b0);
        sf_case(32'h05, 5'b01010, 1'b1, 1'b0);
        sf_case(32'h03, 5'b00100, 1'b1, 1'b0);
        sf_case(32'h01, 5'b00100, 1'b0, 1'b0);
        sf_case(32'h01, 5'b00001, 1'b0, 1'b1);
        sf_case(32'h01, 5'b00000, 1'b0, 1'b0);
    endtask : t_sf

    // Signal fail event behind its mask, then the source path all-ONEs.
    task automatic t_irq_src;
        logic [31:0] d;
        rd(tsm_pkg::A_INT_STAT, d);
        wr(tsm_pkg::A_INT_MASK, 32'h0);
        server_fail_flag <= 1'b1;
        src_valid <= 1'b1;
        src_data <= 8'h3c;
        repeat (3) @(posedge clk_sys);
        chb(irq, 1'b0);
        chk({24'h0, src_out_data}, 32'hff);
        chb(src_out_valid, 1'b1);
        wr(tsm_pkg::A_INT_MASK, 32'h1 << tsm_pkg::I_SF);
        @(posedge clk_sys);
        chb(irq, 1'b1);
        rd(tsm_pkg::A_INT_STAT, d);
        chb(d[tsm_pkg::I_SF], 1'b1);
        server_fail_flag <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chb(irq, 1'b0);
        chk({24'h0, src_out_data}, 32'h3c);
    endtask : t_irq_src

    task automatic t_type;
        for (int t = 0; t < 4; t++) begin
            wr(tsm_pkg::A_CTRL, 32'h09 | (t << tsm_pkg::C_TYPE_LSB));
            frame_loss_defect <= 1'b1;
            repeat (3) @(posedge clk_sys);
            chk({30'h0, tx_alarm_type}, t);
            frame_loss_defect <= 1'b0;
            repeat (3) @(posedge clk_sys);
            chk({30'h0, tx_alarm_type}, {30'h0, tsm_pkg::TYPE_NONE});
        end
        wr(tsm_pkg::A_CTRL, 32'h21);
        frame_loss_defect <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({30'h0, tx_alarm_type}, {30'h0, tsm_pkg::TYPE_NONE});
        frame_loss_defect <= 1'b0;
        wr(tsm_pkg::A_CTRL, 32'h01);
    endtask : t_type

    // Far-end count growth over several short seconds.
    task automatic fe_delta(output logic [31:0] dlt);
        logic [31:0] a;
        logic [31:0] b;
        repeat (150) @(posedge clk_sys);
        rd(tsm_pkg::A_FE_ERR, a);
        repeat (300) @(posedge clk_sys);
        rd(tsm_pkg::A_FE_ERR, b);
        dlt = b - a;
    endtask : fe_delta

    task automatic t_fe;
        logic [31:0] d;
        rei_val <= 4'h3;
        fe_delta(d);
        chb(d != 0 && d % 3 == 0, 1'b1);
        rdi_val <= 1'b1;
        fe_delta(d);
        chk(d, 32'h0);
        rdi_val <= 1'b0;
        wr(tsm_pkg::A_CTRL, 32'h00);
        fe_delta(d);
        chk(d, 32'h0);
        wr(tsm_pkg::A_CTRL, 32'h01);
        frame_loss_defect <= 1'b1;
        fe_delta(d);
        chk(d, 32'h0);
        frame_loss_defect <= 1'b0;
    endtask : t_fe

    // Free-running clock at 50 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Main sequence: every input defined at time zero, reset for 3 cycles.
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {src_valid, src_data, server_fail_flag, frame_loss_defect} = '0;
        {unequipped_defect, trace_mismatch_defect, degraded_defect} = '0;
        {accepted_trace_zero, k2_ais, ptr_ais, rdi_val, rei_val} = '0;
        corrupt_tog = 1'b0;
        trace_val = 8'h47;
        err_count = 0;
        checks_done = 0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs;
        t_code;
        t_ais(1'b0);
        t_ais(1'b1);
        t_sf;
        t_irq_src;
        t_type;
        t_fe;
        complete_run;
    end

    // Watchdog well beyond the few thousand cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        complete_run;
    end
endmodule : tsm_monitor_test
`default_nettype wire
